// File: design/tbc_pkg.sv
package tbc_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Register offsets on the device's register port.
  localparam logic [15:0] ADDR_BUF_CFG = 16'h010A;
  localparam logic [15:0] ADDR_TX_EVENT = 16'h0128;
  localparam logic [15:0] ADDR_BUF_EVENT = 16'h012C;
  localparam logic [15:0] ADDR_BUS_ST = 16'h0138;
  localparam logic [15:0] ADDR_TX_CMD = 16'h0144;
  localparam logic [15:0] ADDR_TX_LEN = 16'h0146;
  localparam logic [15:0] ADDR_DATA = 16'h0A00;

  //////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int CMD_START_LSB = 6;
  localparam int CMD_START_MSB = 7;
  localparam int CMD_FORCE = 8;
  localparam int CMD_ONE_COLL = 9;
  localparam int CMD_FCS_SUPPRESS = 12;
  localparam int CMD_PAD_DISABLE = 13;
  localparam int CFG_READY_IRQ_EN = 8;
  localparam int ST_BID_ERROR = 7;
  localparam int ST_READY_NOW = 8;
  localparam int BEV_READY = 8;
  localparam int BEV_UNDERRUN = 9;
  localparam int TEV_SENT = 8;
  localparam int TEV_LATE_COLL = 9;
  localparam int TEV_JABBER = 10;
  localparam int TEV_EXCESS_COLL = 15;

  //////////////////////////////////////////////////////////////////////////
  // Reset values and masks.
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] CFG_WRITE_MASK = 16'h0100;
  localparam logic [15:0] ALL_ONES = 16'hFFFF;

  //////////////////////////////////////////////////////////////////////////
  // Start thresholds, selected by the two start bits of the command.
  localparam logic [1:0] START_SEL_5 = 2'h0;
  localparam logic [1:0] START_SEL_381 = 2'h2;
  localparam logic [1:0] START_SEL_1021 = 2'h1;
  localparam logic [15:0] START_BYTES_5 = 16'h0005;
  localparam logic [15:0] START_BYTES_381 = 16'h017D;
  localparam logic [15:0] START_BYTES_1021 = 16'h03FD;

  //////////////////////////////////////////////////////////////////////////
  // Frame length limits in bytes: 3, 60, 1514 and 1518.
  localparam logic [15:0] LEN_MIN = 16'h0003;
  localparam logic [15:0] LEN_PAD = 16'h003C;
  localparam logic [15:0] LEN_FCS_LIMIT = 16'h05EA;
  localparam logic [15:0] LEN_MAX = 16'h05EE;

  //////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic [2:0] {
    BID_IDLE,
    BID_LEN,
    BID_WAIT,
    BID_NOW,
    BID_EVT
  } tbc_bid_e;

  typedef struct packed {
    logic ok;
    logic excess_coll;
    logic jabber;
    logic late_coll;
  } tbc_result_s;

  typedef struct packed {
    logic [15:0] len;
    logic [15:0] wire_len;
    logic append_fcs;
    logic one_coll;
  } tbc_frame_s;

endpackage

// File: design/tbc_fifo.sv
`timescale 1ns/1ps

// DEPTH must be a power of two; the pointers wrap by plain overflow.
module tbc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_flush,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] COUNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0] COUNT_EMPTY = '0;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;

  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  assign o_out_data = mem[rd_ptr];

  //////////////////////////////////////////////////////////////////////////
  // Flags are registered so both handshakes leave straight from flops.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= COUNT_EMPTY;
      o_in_ready <= 1'b1;
      o_out_valid <= 1'b0;
    end else if (i_flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= COUNT_EMPTY;
      o_in_ready <= 1'b1;
      o_out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      count <= next_count;
      o_in_ready <= next_count != COUNT_FULL;
      o_out_valid <= next_count != COUNT_EMPTY;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

endmodule

// File: design/tbc_top.sv
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Contract
// RULE1: Enough space at request sets ready-now flag.
// RULE2: No space, irq enabled: event flag later.
// RULE3: No space, irq disabled: ready-now flag later.
// RULE4: Commit only after good bid and set-read.
// RULE5: Committed space never taken by later frame.
// RULE6: Line failures raise one of three flags.
// RULE7: Force bit discards committed and queued frames.
// RULE8: Host programs length zero when forcing.
// RULE9: Late host data abandons frame, sets underrun.
// RULE10: Successful send sets frame-sent flag.
// RULE11: Sent length comes from length register.
// RULE12: Pad-disable and fcs-suppress shape the frame.
// RULE13: Short frames padded to 60 unless disabled.
// RULE14: 1514 to 1518 need suppress; above 1518 never.
// RULE15: Lengths below three bytes are refused.
// RULE16: Full duplex host waits before long bids.
// RULE17: Host bids: command, length, then status read.
// RULE18: Invalid length discards bid, sets bid error.
// RULE19: Any frame outcome releases its committed space.
module tbc_top #(
  parameter logic [15:0] BUF_BYTES = 16'h0C00,
  parameter int DATA_W = 16,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_bus_cs,
  input wire logic i_bus_we,
  input wire logic i_bus_re,
  input wire logic [15:0] i_bus_addr,
  input wire logic [DATA_W-1:0] i_bus_wdata,
  output logic [15:0] o_bus_rdata,
  output logic o_bus_rvalid,
  output logic o_data_ready,
  output tbc_pkg::tbc_frame_s o_tx_frame,
  output logic o_tx_req,
  output logic o_tx_abort,
  output logic [DATA_W-1:0] o_tx_data,
  output logic o_tx_valid,
  input wire logic i_tx_ready,
  input wire logic i_line_done,
  input wire tbc_pkg::tbc_result_s i_line_result
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.
  wire wr = i_bus_cs && i_bus_we;
  wire rd = i_bus_cs && i_bus_re && !i_bus_we;
  wire wr_cmd = wr && (i_bus_addr == tbc_pkg::ADDR_TX_CMD);
  wire wr_len = wr && (i_bus_addr == tbc_pkg::ADDR_TX_LEN);
  wire wr_cfg = wr && (i_bus_addr == tbc_pkg::ADDR_BUF_CFG);
  wire wr_data = wr && (i_bus_addr == tbc_pkg::ADDR_DATA);
  wire rd_cmd = rd && (i_bus_addr == tbc_pkg::ADDR_TX_CMD);
  wire rd_len = rd && (i_bus_addr == tbc_pkg::ADDR_TX_LEN);
  wire rd_cfg = rd && (i_bus_addr == tbc_pkg::ADDR_BUF_CFG);
  wire rd_st = rd && (i_bus_addr == tbc_pkg::ADDR_BUS_ST);
  wire rd_bev = rd && (i_bus_addr == tbc_pkg::ADDR_BUF_EVENT);
  wire rd_tev = rd && (i_bus_addr == tbc_pkg::ADDR_TX_EVENT);

  logic [15:0] tx_cmd;
  logic [15:0] tx_len;
  logic [15:0] buf_cfg;
  logic [15:0] tx_event;
  logic [15:0] buf_event;
  logic bid_err;
  tbc_pkg::tbc_bid_e bid;
  tbc_pkg::tbc_bid_e next_bid;
  logic frame_busy;
  logic [15:0] words_total;
  logic [15:0] words_in;
  logic [15:0] words_out;
  logic [15:0] start_bytes;
  logic fifo_out_valid;
  logic [DATA_W-1:0] fifo_out_data;

  ////////////////////////////////////////////////////////////////////////////
  // Length policy.
  wire force_cmd = tx_cmd[tbc_pkg::CMD_FORCE];
  wire pad_dis = tx_cmd[tbc_pkg::CMD_PAD_DISABLE];
  wire fcs_sup = tx_cmd[tbc_pkg::CMD_FCS_SUPPRESS];
  wire irq_en = buf_cfg[tbc_pkg::CFG_READY_IRQ_EN];
  wire in_len = bid == tbc_pkg::BID_LEN;
  wire [15:0] len_src = in_len ? i_bus_wdata[15:0] : tx_len;
  wire len_ok = (len_src >= tbc_pkg::LEN_MIN) // [RULE15]
    && (len_src <= tbc_pkg::LEN_MAX) // [RULE14]
    && (fcs_sup || (len_src < tbc_pkg::LEN_FCS_LIMIT)); // [RULE14]
  // Padding applies even with the fcs suppressed. [RULE13]
  wire pad_short = !pad_dis && (len_src < tbc_pkg::LEN_PAD);
  wire [15:0] wire_len = pad_short ? tbc_pkg::LEN_PAD : len_src; // [RULE12]
  // One commitment at a time keeps the committed space private. [RULE5]
  wire space_ok = !frame_busy && (wire_len <= BUF_BYTES);
  wire len_take = wr_len && in_len && !force_cmd;
  wire len_bad = len_take && !len_ok; // [RULE18]

  ////////////////////////////////////////////////////////////////////////////
  // Commitment and frame outcome decode.
  wire commit_st = rd_st && (bid == tbc_pkg::BID_NOW); // [RULE4]
  wire commit_ev = rd_bev && (bid == tbc_pkg::BID_EVT)
    && buf_event[tbc_pkg::BEV_READY]; // [RULE4]
  wire commit = commit_st || commit_ev;
  wire wait_done = (bid == tbc_pkg::BID_WAIT) && space_ok;
  wire ev_ready_set = wait_done && irq_en; // [RULE2]
  wire flush = wr_cmd && i_bus_wdata[tbc_pkg::CMD_FORCE]; // [RULE7]
  wire push_ok = wr_data && frame_busy && (words_in < words_total);
  wire accepted = push_ok && o_data_ready;
  wire out_ready = o_tx_req && (!o_tx_valid || i_tx_ready);
  wire out_load = out_ready && fifo_out_valid;
  // The line asks for a word that neither stage holds. [RULE9]
  wire underrun = o_tx_req && i_tx_ready && !o_tx_valid && !fifo_out_valid
    && (words_out < words_total);
  wire line_end = frame_busy && i_line_done;
  wire release_frame = line_end || underrun || flush; // [RULE19]
  wire [15:0] bytes_in = {words_in[14:0], 1'b0};
  wire start_tx = frame_busy && !o_tx_req
    && ((words_in == words_total) || (bytes_in >= start_bytes));
  wire [16:0] len_round = {1'b0, tx_len} + 17'h00001;
  wire [1:0] start_sel = tx_cmd[tbc_pkg::CMD_START_MSB:tbc_pkg::CMD_START_LSB];
  wire [15:0] start_pick =
    (start_sel == tbc_pkg::START_SEL_5) ? tbc_pkg::START_BYTES_5 :
    (start_sel == tbc_pkg::START_SEL_381) ? tbc_pkg::START_BYTES_381 :
    (start_sel == tbc_pkg::START_SEL_1021) ? tbc_pkg::START_BYTES_1021 :
    tx_len;

  ////////////////////////////////////////////////////////////////////////////
  // Sticky events; a set in the cycle of the clearing read wins.
  logic [15:0] tx_ev_set;
  logic [15:0] buf_ev_set;
  logic [15:0] st_word;
  always_comb begin
    tx_ev_set = tbc_pkg::REG_RESET;
    tx_ev_set[tbc_pkg::TEV_SENT] = line_end && i_line_result.ok; // [RULE10]
    tx_ev_set[tbc_pkg::TEV_EXCESS_COLL] =
      line_end && i_line_result.excess_coll; // [RULE6]
    tx_ev_set[tbc_pkg::TEV_JABBER] =
      line_end && i_line_result.jabber; // [RULE6]
    tx_ev_set[tbc_pkg::TEV_LATE_COLL] =
      line_end && i_line_result.late_coll; // [RULE6]
    buf_ev_set = tbc_pkg::REG_RESET;
    buf_ev_set[tbc_pkg::BEV_READY] = ev_ready_set;
    buf_ev_set[tbc_pkg::BEV_UNDERRUN] = underrun; // [RULE9]
    st_word = tbc_pkg::REG_RESET;
    st_word[tbc_pkg::ST_BID_ERROR] = bid_err;
    st_word[tbc_pkg::ST_READY_NOW] = bid == tbc_pkg::BID_NOW;
  end

  wire [15:0] next_tx_event = (rd_tev ? tbc_pkg::REG_RESET : tx_event)
    | tx_ev_set;
  wire [15:0] next_buf_event = (rd_bev ? tbc_pkg::REG_RESET : buf_event)
    | buf_ev_set;
  wire next_bid_err = (bid_err && !wr_cmd) || len_bad; // [RULE18]
  wire [15:0] rd_word =
    rd_cmd ? tx_cmd :
    rd_len ? tx_len :
    rd_cfg ? buf_cfg :
    rd_st ? st_word :
    rd_bev ? buf_event :
    rd_tev ? tx_event :
    tbc_pkg::REG_RESET;

  ////////////////////////////////////////////////////////////////////////////
  // Bid sequencing.
  always_comb begin
    next_bid = bid;
    case (bid)
      tbc_pkg::BID_IDLE: begin
        next_bid = tbc_pkg::BID_IDLE;
      end
      tbc_pkg::BID_LEN: begin
        if (wr_len) begin
          if (force_cmd || !len_ok) begin
            next_bid = tbc_pkg::BID_IDLE; // [RULE18]
          end else if (space_ok) begin
            next_bid = tbc_pkg::BID_NOW; // [RULE1]
          end else begin
            next_bid = tbc_pkg::BID_WAIT;
          end
        end
      end
      tbc_pkg::BID_WAIT: begin
        if (wait_done) begin
          // With interrupts disabled the poll flag stands instead. [RULE3]
          next_bid = irq_en ? tbc_pkg::BID_EVT : tbc_pkg::BID_NOW; // [RULE2]
        end
      end
      tbc_pkg::BID_NOW: begin
        if (commit_st) begin
          next_bid = tbc_pkg::BID_IDLE;
        end
      end
      tbc_pkg::BID_EVT: begin
        if (commit_ev) begin
          next_bid = tbc_pkg::BID_IDLE;
        end
      end
      default: begin
        next_bid = tbc_pkg::BID_IDLE;
      end
    endcase
    if (wr_cmd) begin
      next_bid = tbc_pkg::BID_LEN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_cmd <= tbc_pkg::REG_RESET;
      tx_len <= tbc_pkg::REG_RESET;
      buf_cfg <= tbc_pkg::REG_RESET;
      tx_event <= tbc_pkg::REG_RESET;
      buf_event <= tbc_pkg::REG_RESET;
      bid_err <= 1'b0;
      bid <= tbc_pkg::BID_IDLE;
      o_bus_rdata <= tbc_pkg::REG_RESET;
      o_bus_rvalid <= 1'b0;
    end else begin
      tx_cmd <= wr_cmd ? i_bus_wdata[15:0] : tx_cmd;
      tx_len <= len_take ? i_bus_wdata[15:0] : tx_len; // [RULE11]
      buf_cfg <= wr_cfg ? (i_bus_wdata[15:0] & tbc_pkg::CFG_WRITE_MASK)
        : buf_cfg;
      tx_event <= next_tx_event;
      buf_event <= next_buf_event;
      bid_err <= next_bid_err;
      bid <= next_bid;
      o_bus_rdata <= rd_word;
      o_bus_rvalid <= rd;
    end
  end

  // A release also drops any frame still queued behind the line. [RULE7]
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      frame_busy <= 1'b0;
      o_tx_req <= 1'b0;
      o_tx_frame <= '0;
      words_total <= tbc_pkg::REG_RESET;
      words_in <= tbc_pkg::REG_RESET;
      words_out <= tbc_pkg::REG_RESET;
      start_bytes <= tbc_pkg::REG_RESET;
    end else if (release_frame) begin
      frame_busy <= 1'b0; // [RULE19]
      o_tx_req <= 1'b0;
    end else if (commit) begin
      frame_busy <= 1'b1; // [RULE4]
      o_tx_frame.len <= tx_len; // [RULE11]
      o_tx_frame.wire_len <= wire_len; // [RULE13]
      o_tx_frame.append_fcs <= !fcs_sup; // [RULE12]
      o_tx_frame.one_coll <= tx_cmd[tbc_pkg::CMD_ONE_COLL];
      words_total <= len_round[16:1];
      words_in <= tbc_pkg::REG_RESET;
      words_out <= tbc_pkg::REG_RESET;
      start_bytes <= start_pick;
    end else begin
      o_tx_req <= o_tx_req || start_tx;
      words_in <= words_in + 16'(accepted);
      words_out <= words_out + 16'(out_load);
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_tx_valid <= 1'b0;
      o_tx_data <= '0;
      o_tx_abort <= 1'b0;
    end else begin
      o_tx_valid <= !release_frame
        && (out_load || (o_tx_valid && !i_tx_ready));
      o_tx_data <= out_load ? fifo_out_data : o_tx_data;
      o_tx_abort <= frame_busy && (underrun || flush); // [RULE9]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame data buffer; a full buffer holds off the host's data writes.
  tbc_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_flush(release_frame),
    .i_in_valid(push_ok),
    .o_in_ready(o_data_ready),
    .i_in_data(i_bus_wdata),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(out_ready),
    .o_out_data(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_ready_now;
    @(posedge i_clk) disable iff (!i_resetn)
    len_take && len_ok && space_ok |=> bid == tbc_pkg::BID_NOW;
  endproperty
  a_ready_now: assert property (p_ready_now) // [RULE1]
    else $error("Ready-now flag missing after bid with space.");

  property p_ready_event;
    @(posedge i_clk) disable iff (!i_resetn)
    ev_ready_set && !wr_cmd |=> buf_event[tbc_pkg::BEV_READY]
      && (bid == tbc_pkg::BID_EVT);
  endproperty
  a_ready_event: assert property (p_ready_event) // [RULE2]
    else $error("Ready event not raised when space freed.");

  property p_ready_poll;
    @(posedge i_clk) disable iff (!i_resetn)
    wait_done && !irq_en && !wr_cmd |=> bid == tbc_pkg::BID_NOW
      && !$rose(buf_event[tbc_pkg::BEV_READY]);
  endproperty
  a_ready_poll: assert property (p_ready_poll) // [RULE3]
    else $error("Poll flag not raised when space freed.");

  property p_commit_cause;
    @(posedge i_clk) disable iff (!i_resetn)
    $rose(frame_busy) |-> $past(commit_st) || $past(commit_ev);
  endproperty
  a_commit_cause: assert property (p_commit_cause) // [RULE4]
    else $error("Space committed without a set-flag read.");

  property p_one_commit;
    @(posedge i_clk) disable iff (!i_resetn)
    frame_busy |-> bid != tbc_pkg::BID_NOW && bid != tbc_pkg::BID_EVT;
  endproperty
  a_one_commit: assert property (p_one_commit) // [RULE5]
    else $error("Second frame granted while space committed.");

  property p_fail_flag;
    @(posedge i_clk) disable iff (!i_resetn)
    line_end && i_line_result.jabber ##1 !rd_tev
      |=> tx_event[tbc_pkg::TEV_JABBER] && !frame_busy;
  endproperty
  a_fail_flag: assert property (p_fail_flag) // [RULE6]
    else $error("Line failure flag lost.");

  property p_flush;
    @(posedge i_clk) disable iff (!i_resetn)
    flush |=> !frame_busy && !o_tx_req && !o_tx_valid ##1 !o_tx_valid;
  endproperty
  a_flush: assert property (p_flush) // [RULE7]
    else $error("Frame survived a force command.");

  property p_underrun;
    @(posedge i_clk) disable iff (!i_resetn)
    underrun |=> buf_event[tbc_pkg::BEV_UNDERRUN] && o_tx_abort && !o_tx_req;
  endproperty
  a_underrun: assert property (p_underrun) // [RULE9]
    else $error("Underrun not reported.");

  property p_sent;
    @(posedge i_clk) disable iff (!i_resetn)
    line_end && i_line_result.ok |=> tx_event[tbc_pkg::TEV_SENT];
  endproperty
  a_sent: assert property (p_sent) // [RULE10]
    else $error("Frame-sent flag not set.");

  property p_pad;
    @(posedge i_clk) disable iff (!i_resetn)
    $rose(frame_busy) |-> (pad_dis || o_tx_frame.wire_len >= tbc_pkg::LEN_PAD)
      && (o_tx_frame.len == tx_len);
  endproperty
  a_pad: assert property (p_pad) // [RULE13]
    else $error("Short frame not padded or length mismatch.");

  property p_bid_error;
    @(posedge i_clk) disable iff (!i_resetn)
    len_take && (i_bus_wdata[15:0] < tbc_pkg::LEN_MIN
      || i_bus_wdata[15:0] > tbc_pkg::LEN_MAX)
      |=> bid_err && bid == tbc_pkg::BID_IDLE;
  endproperty
  a_bid_error: assert property (p_bid_error) // [RULE18]
    else $error("Bad length accepted without bid error.");

  property p_release;
    @(posedge i_clk) disable iff (!i_resetn)
    line_end || underrun |=> !frame_busy ##1 o_data_ready;
  endproperty
  a_release: assert property (p_release) // [RULE19]
    else $error("Committed space not released.");

endmodule

// File: sim/tbc_line_model.sv
`timescale 1ns/1ps

// Line side: takes words while the frame is started and reports one outcome.
module tbc_line_model (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_tx_req,
  input wire logic i_tx_abort,
  input wire logic i_tx_valid,
  input wire tbc_pkg::tbc_frame_s i_frame,
  input wire logic i_stall,
  input wire tbc_pkg::tbc_result_s i_outcome,
  output logic o_tx_ready,
  output logic o_done,
  output tbc_pkg::tbc_result_s o_result
);
  logic [15:0] taken;
  wire [15:0] need = (i_frame.len + 16'h0001) >> 1;

  // Stalling lets the bench fill the buffer before the line drains it.
  assign o_tx_ready = i_tx_req && !i_stall;
  // Outside the done pulse the result is inverted so it is never trusted.
  assign o_result = o_done ? i_outcome : ~i_outcome;

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      taken <= 16'h0000;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (!i_tx_req || i_tx_abort) begin
        taken <= 16'h0000;
      end else if (i_tx_valid && o_tx_ready) begin
        taken <= taken + 16'h0001;
        if (taken + 16'h0001 == need) begin
          o_done <= 1'b1;
          taken <= 16'h0000;
        end
      end
    end
  end
endmodule

// File: sim/tbc_top_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end

module tbc_top_tb;
  logic i_clk, i_resetn, cs, we, re, stall, req, abort, valid, ready;
  logic done, drdy, rv;
  logic [15:0] addr, wdata, rdata, st, txd;
  tbc_pkg::tbc_frame_s frame;
  tbc_pkg::tbc_result_s res, outcome;
  int fails, n_checks, k;

  initial begin
    i_clk = 0;
    forever #2.5 i_clk = ~i_clk;
  end

  tbc_top dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_bus_cs(cs),
    .i_bus_we(we), .i_bus_re(re), .i_bus_addr(addr), .i_bus_wdata(wdata),
    .o_bus_rdata(rdata), .o_bus_rvalid(rv), .o_data_ready(drdy),
    .o_tx_frame(frame), .o_tx_req(req), .o_tx_abort(abort), .o_tx_data(txd),
    .o_tx_valid(valid), .i_tx_ready(ready), .i_line_done(done),
    .i_line_result(res));

  tbc_line_model line (.i_clk(i_clk), .i_resetn(i_resetn), .i_tx_req(req),
    .i_tx_abort(abort), .i_tx_valid(valid), .i_frame(frame),
    .i_stall(stall), .i_outcome(outcome), .o_tx_ready(ready),
    .o_done(done), .o_result(res));

  //////////////////////////////////////////////////////////////////////////
  task automatic acc(input logic w, input logic [15:0] a,
    input logic [15:0] d);
    @(posedge i_clk);
    cs <= 1'b1;
    we <= w;
    re <= !w;
    addr <= a;
    wdata <= d;
    @(posedge i_clk);
    cs <= 1'b0;
    we <= 1'b0;
    re <= 1'b0;
    @(negedge i_clk);
    st = rdata;
    `CHK(rv, !w)
  endtask

  task automatic bid(input logic [15:0] cmd, input logic [15:0] len);
    acc(1, tbc_pkg::ADDR_TX_CMD, cmd);
    acc(1, tbc_pkg::ADDR_TX_LEN, len);
    acc(0, tbc_pkg::ADDR_BUS_ST, 16'h0000);
  endtask

  task automatic wait_for(input bit ab);
    k = 0;
    while (!(ab ? abort : done) && k < 400) begin
      @(negedge i_clk);
      k++;
    end
    `CHK(k < 400, 1'b1)
  endtask

  task automatic drop;
    acc(1, tbc_pkg::ADDR_TX_CMD, 16'h0100);
    wait_for(1);
    acc(1, tbc_pkg::ADDR_TX_LEN, 16'h0000);
    `CHK(req, 1'b0)
  endtask

  task automatic put(input int n);
    for (int j = 0; j < n; j++) begin
      acc(1, tbc_pkg::ADDR_DATA, 16'(j));
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_outcome;
    logic [3:0] oc[4] = '{4'h8, 4'h4, 4'h2, 4'h1};
    int pos[4] = '{8, 15, 10, 9};
    for (int i = 0; i < 4; i++) begin
      outcome = oc[i];
      bid(16'h00C0, 16'h001E);
      `CHK(st[8], 1'b1)
      `CHK(frame, {16'h001E, 16'h003C, 2'h2})
      put(15);
      wait_for(0);
      `CHK(txd, 16'h000E)
      acc(0, tbc_pkg::ADDR_TX_EVENT, 16'h0000);
      `CHK(st[pos[i]], 1'b1)
      acc(0, tbc_pkg::ADDR_TX_EVENT, 16'h0000);
      `CHK(st, 16'h0000)
    end
  endtask

  task automatic t_shape;
    for (int i = 0; i < 4; i++) begin
      bid(16'h00C0 | (i[0] ? 16'h1000 : 16'h0000) |
        (i[1] ? 16'h2000 : 16'h0000), 16'h000A);
      `CHK(frame.wire_len, i[1] ? 16'h000A : 16'h003C)
      `CHK(frame.append_fcs, !i[0])
      drop();
    end
  endtask

  task automatic t_refuse;
    logic [15:0] len[4] = '{16'h0002, 16'h05EA, 16'h05EE, 16'h05EF};
    logic [15:0] cmd[4] = '{16'h1000, 16'h0000, 16'h0000, 16'h1000};
    for (int i = 0; i < 4; i++) begin
      bid(cmd[i], len[i]);
      `CHK(st[8:7], 2'h1)
    end
    bid(16'h10C0, 16'h05EE);
    `CHK(st[8:7], 2'h2)
    drop();
    bid(16'h00C0, 16'h0003);
    `CHK(st[8:7], 2'h2)
    drop();
  endtask

  task automatic t_wait(input bit irq);
    acc(1, tbc_pkg::ADDR_BUF_CFG, irq ? 16'hFFFF : 16'h0000);
    acc(0, tbc_pkg::ADDR_BUF_CFG, 16'h0000);
    `CHK(st, irq ? 16'h0100 : 16'h0000)
    bid(16'h00C0, 16'h000A);
    bid(16'h00C0, 16'h000A);
    `CHK(st[8], 1'b0)
    put(5);
    wait_for(0);
    // Space frees a cycle after the release, so the host keeps polling.
    k = 0;
    do begin
      acc(0, irq ? tbc_pkg::ADDR_BUF_EVENT : tbc_pkg::ADDR_BUS_ST, 16'h0000);
      k++;
    end while (!st[8] && k < 8);
    `CHK(st[8], 1'b1)
    drop();
  endtask

  // The line stalls so the buffer fills; releasing it drains to empty.
  task automatic t_underrun;
    bid(16'h0000, 16'h0064);
    stall = 1'b1;
    k = 0;
    while (drdy && k < 40) begin
      acc(1, tbc_pkg::ADDR_DATA, 16'(k));
      k++;
    end
    `CHK(k >= 16 && k < 40, 1'b1)
    stall = 1'b0;
    wait_for(1);
    acc(0, tbc_pkg::ADDR_BUF_EVENT, 16'h0000);
    `CHK(st[9], 1'b1)
    `CHK(req, 1'b0)
  endtask

  //////////////////////////////////////////////////////////////////////////
  task print_verdict;
    if (fails == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    {i_resetn, cs, we, re, stall} = '0;
    addr = 16'h0000;
    wdata = 16'h0000;
    outcome = 4'h8;
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'b1;
    acc(0, 16'h0000, 16'h0000);
    `CHK(st, 16'h0000)
    t_outcome();
    t_shape();
    t_refuse();
    t_wait(0);
    t_wait(1);
    t_underrun();
    print_verdict();
  end

  initial begin
    #400000;
    fails++;
    print_verdict();
  end
endmodule
